// ---- shared/memory_configuration_map.vh ----
// Field positions, reset values and field codes of the memory configuration register.
// Assumes a single 10 MHz processor clock and a global-register write strobe from the core.
// Operation
// - Page code picks column range top bit 15 down to 8; bottom bit by bus width.
// - Register is write-only; software can never read its contents back.
// - Reset sets every register bit to one.
// - Bit 25 one gives rail-to-rail output, zero gives reduced level.
// - Bit 24 one selects 5.0 V input threshold, zero selects 3.3 V.
// - Bit 22 one keeps processor active, zero requests power-down.
// - Bit 21 one marks space zero non-DRAM, zero marks it DRAM.
// - Bit 20 one is normal internal RAM refresh, zero is refresh test.
// - Bits 18:16 set refresh interval 2 to 128 cycles; 111 disables refresh.
// - Bits 14:12 place entry table in space 0,1,2, internal RAM or space 3.
// - Bits 11:8 are hold-break controls for spaces 3..0; zero enables.
// - Two-bit width per space: 11 8-bit, 10 16-bit, 00 32-bit, 01 reserved.
// - Power-down starts only on a one-to-zero change of the sleep bit.
// - Entry waits for pipeline drain; interrupt wakes without setting bit, reset wakes and sets it.
// - Enabled hold break skips hold cycles for a same-space next access.
// - Space three places table at its end; other choices at the beginning.
`ifndef MEMORY_CONFIGURATION_MAP_VH
`define MEMORY_CONFIGURATION_MAP_VH
`define MCFG_RESET 32'hFFFF_FFFF
`define MCFG_OUT_LEVEL 25
`define MCFG_IN_LEVEL 24
`define MCFG_SLEEP 22
`define MCFG_S0_KIND 21
`define MCFG_REF_CHECK 20
`define MCFG_REF_HI 18
`define MCFG_REF_LO 16
`define MCFG_VEC_HI 14
`define MCFG_VEC_LO 12
`define MCFG_SKIP_HI 11
`define MCFG_SKIP_LO 8
`define MCFG_W3_LO 6
`define MCFG_W2_LO 4
`define MCFG_W1_LO 2
`define MCFG_W0_LO 0
`define WIDTH_8 2'h3
`define WIDTH_16 2'h2
`define WIDTH_32 2'h0
`define REF_OFF 3'h7
`define PAGE_TOP_BASE 4'hF
`define VEC_S0 3'h0
`define VEC_S1 3'h1
`define VEC_S2 3'h2
`define VEC_INTERNAL_RAM 3'h3
`define VEC_S3 3'h7
`define VEC_AT_END 1'h1
`endif

// ---- design/memory_configuration_register.v ----
// Write-only memory configuration register with decoded field outputs.
// Assumes the core drives a one-cycle write strobe for the global register slot
// and reports memory pipeline idle, interrupt and the selected space of accesses.
`include "memory_configuration_map.vh"
`default_nettype none
module memory_configuration_register (
  input wire mclk,
  input wire reset,
  input wire cfgWrite,
  input wire [31:0] cfgData,
  input wire [2:0] dramPageCode,
  input wire pipeEmpty,
  input wire wakeEvent,
  input wire [1:0] curSpace,
  input wire [1:0] nextSpace,
  input wire nextValid,
  output reg outputDriveLevel,
  output reg inputLevelSelect,
  output reg spaceZeroIsDram,
  output reg refreshCheckMode,
  output reg refreshEnable,
  output reg [7:0] refreshInterval,
  output reg [2:0] vectorTablePlacement,
  output reg vectorTableAtEnd,
  output reg vectorTableValid,
  output reg [3:0] holdSkip,
  output reg [7:0] spaceWidths,
  output reg [3:0] columnTopBit,
  output reg [1:0] columnLowBit,
  output wire skipHold,
  output reg sleeping
);

  localparam ST_ACTIVE = 3'b001;
  localparam ST_DRAIN = 3'b010;
  localparam ST_SLEEP = 3'b100;

  reg [31:0] config_r;
  reg sleepPrev_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;

  // Lowest column bit from a two-bit width code; reserved code treated as 32-bit.
  function [1:0] low_bit;
    input [1:0] w;
    begin
      case (w)
        `WIDTH_8: low_bit = 2'h0;
        `WIDTH_16: low_bit = 2'h1;
        default: low_bit = 2'h2;
      endcase
    end
  endfunction

  // Holding register; not readable anywhere on the core side.
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      config_r <= `MCFG_RESET;
    end else if (cfgWrite) begin
      config_r <= cfgData;
    end
  end

  // Decoded outputs follow the register one cycle after a write; columnTopBit follows dramPageCode each cycle.
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      outputDriveLevel <= 1'b1;
      inputLevelSelect <= 1'b1;
      spaceZeroIsDram <= 1'b0;
      refreshCheckMode <= 1'b0;
      refreshEnable <= 1'b0;
      refreshInterval <= 8'h01;
      vectorTablePlacement <= `VEC_S3;
      vectorTableAtEnd <= 1'b1;
      vectorTableValid <= 1'b1;
      holdSkip <= 4'h0;
      spaceWidths <= 8'hFF;
      columnTopBit <= 4'h8;
      columnLowBit <= 2'h0;
    end else begin
      outputDriveLevel <= config_r[`MCFG_OUT_LEVEL];
      inputLevelSelect <= config_r[`MCFG_IN_LEVEL];
      spaceZeroIsDram <= ~config_r[`MCFG_S0_KIND];
      refreshCheckMode <= ~config_r[`MCFG_REF_CHECK];
      refreshEnable <= config_r[`MCFG_REF_HI:`MCFG_REF_LO] != `REF_OFF;
      refreshInterval <= 8'h80 >> config_r[`MCFG_REF_HI:`MCFG_REF_LO];
      vectorTablePlacement <= config_r[`MCFG_VEC_HI:`MCFG_VEC_LO];
      vectorTableAtEnd <= config_r[`MCFG_VEC_HI:`MCFG_VEC_LO] == `VEC_S3;
      vectorTableValid <= config_r[`MCFG_VEC_HI:`MCFG_VEC_LO] <= `VEC_INTERNAL_RAM ||
        config_r[`MCFG_VEC_HI:`MCFG_VEC_LO] == `VEC_S3;
      holdSkip <= ~config_r[`MCFG_SKIP_HI:`MCFG_SKIP_LO];
      spaceWidths <= config_r[7:0];
      columnTopBit <= `PAGE_TOP_BASE - {1'b0, dramPageCode};
      columnLowBit <= low_bit(config_r[`MCFG_W0_LO+1:`MCFG_W0_LO]);
    end
  end

  // Hold cycles are skipped when the break is enabled and the space repeats.
  assign skipHold = nextValid && (nextSpace == curSpace) && holdSkip[curSpace];

  // Power-down sequencer.
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_ACTIVE: begin
        if (sleepPrev_r && !config_r[`MCFG_SLEEP]) begin
          state_nxt = pipeEmpty ? ST_SLEEP : ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        if (wakeEvent) begin
          state_nxt = ST_ACTIVE;
        end else if (pipeEmpty) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wakeEvent) begin
          state_nxt = ST_ACTIVE;
        end
      end
      default: state_nxt = ST_ACTIVE;
    endcase
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_r <= ST_ACTIVE;
      sleepPrev_r <= 1'b1;
      sleeping <= 1'b0;
    end else begin
      state_r <= state_nxt;
      sleepPrev_r <= config_r[`MCFG_SLEEP];
      sleeping <= state_nxt == ST_SLEEP;
    end
  end

endmodule // memory_configuration_register
`default_nettype wire

// ---- verification/mem_space_model.sv ----
// Far-side access stream model.
// The bench steers the stall input.
`default_nettype none
module mem_space_model (
  input wire logic mclk,
  input wire logic stall,
  output logic pipeEmpty,
  output logic nextValid,
  output logic [1:0] curSpace,
  output logic [1:0] nextSpace
);
  timeunit 1ns / 1ns;
  logic [4:0] n = 5'h0;
  always @(posedge mclk) n <= #1 n + 5'h1;
  assign {nextSpace, curSpace, nextValid} = n;
  assign pipeEmpty = !stall;
endmodule // mem_space_model
`default_nettype wire

// ---- verification/mcr_checker.sv ----
// Port assertions on the configuration register.
// Bound onto the register module.
`default_nettype none
module memory_config_checker (
  input wire logic mclk, reset, cfgWrite, pipeEmpty, wakeEvent, nextValid, skipHold, sleeping,
  input wire logic outputDriveLevel, inputLevelSelect, refreshEnable,
  input wire logic spaceZeroIsDram, refreshCheckMode,
  input wire logic [31:0] cfgData,
  input wire logic [2:0] dramPageCode,
  input wire logic [1:0] curSpace, nextSpace,
  input wire logic [7:0] refreshInterval,
  input wire logic [3:0] holdSkip, columnTopBit
);
  timeunit 1ns / 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence wr;
    cfgWrite ##2 1'b1;
  endsequence
  AST_IO: assert property (wr |->
    {outputDriveLevel, inputLevelSelect} == $past(cfgData[25:24], 2)) else $error("io");
  AST_RATE: assert property (wr |-> refreshEnable == !(&$past(cfgData[18:16], 2))
    && refreshInterval == 8'h80 >> $past(cfgData[18:16], 2)) else $error("rate");
  AST_SKIP: assert property (wr |-> holdSkip == ~$past(cfgData[11:8], 2)) else $error("s");
  AST_KIND: assert property (wr |->
    {spaceZeroIsDram, refreshCheckMode} == ~$past(cfgData[21:20], 2)) else $error("kind");
  AST_HOLD: assert property (skipHold == (nextValid && nextSpace == curSpace
    && holdSkip[curSpace])) else $error("hold");
  AST_PAGE: assert property (!$past(reset) |->
    columnTopBit == 4'hF - $past(dramPageCode)) else $error("page");
  AST_DRAIN: assert property ($rose(sleeping) |-> $past(pipeEmpty)) else $error("d");
  AST_WAKE: assert property (sleeping && wakeEvent |=> !sleeping) else $error("w");
  AST_STAY: assert property (sleeping && !wakeEvent |=> sleeping) else $error("z");
endmodule // memory_config_checker
bind memory_configuration_register memory_config_checker chk (.*);
`default_nettype wire

// ---- verification/memory_configuration_register_tb_top.sv ----
// Bench for the configuration register.
// Far model and checker compile first.
`default_nettype none
module memory_configuration_register_tb_top;
  timeunit 1ns / 1ns;
  logic mclk = 1'h0, reset = 1'h1, cfgWrite = 1'h0, wakeEvent = 1'h0, stall = 1'h1;
  logic pipeEmpty, nextValid, skipHold, sleeping, outputDriveLevel, inputLevelSelect;
  logic spaceZeroIsDram, refreshCheckMode, refreshEnable, vectorTableAtEnd, vectorTableValid;
  logic [31:0] cfgData = 32'h0;
  logic [2:0] dramPageCode = 3'h0, vectorTablePlacement;
  logic [1:0] curSpace, nextSpace, columnLowBit, wd = 2'h0;
  logic [7:0] refreshInterval, spaceWidths;
  logic [3:0] holdSkip, columnTopBit;
  logic [14:0] q[$];
  int error_cnt = 0, num_checks = 0;
  wire [14:0] got = {vectorTablePlacement, vectorTableAtEnd, vectorTableValid, spaceWidths,
    columnLowBit};
  always #50 mclk = ~mclk;
  memory_configuration_register dut (.*);
  mem_space_model far (.*);
  task automatic chk(input string n, input logic [14:0] s, e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [31:0] d);
    cfgData = d | 32'hFC88_8000;
    cfgWrite = 1'h1;
    dramPageCode = 3'($urandom);
    q.push_back({d[14:12], &d[14:12], !d[14] || &d[14:12], d[7:0], d[1] ? {1'h0, !d[0]} : 2'h2});
    tick(1);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge mclk) begin
    wd = {wd[0], cfgWrite};
    #2;
    if (wd[1]) chk("fields", got, q.pop_front());
  end
  initial begin
    #100000;
    error_cnt++;
    report_and_stop;
  end
  initial begin
    void'($urandom(83178));
    tick(5);
    reset = 1'h0;
    chk("reset", got, 15'h7FFC);
    $display("reset test done");
    for (int i = 0; i < 8; i++) wr($urandom & 32'hFFB8_8FFC | 32'h0040_0000 | i * 32'h1_1000 | i & 3);
    cfgWrite = 1'h0;
    tick(3);
    $display("code test done");
    wr(32'hFFBF_FFFF);
    cfgWrite = 1'h0;
    tick(4);
    chk("drain", sleeping, 15'h0);
    stall = 1'h0;
    tick(2);
    chk("sleep", sleeping, 15'h1);
    wakeEvent = 1'h1;
    tick(1);
    wakeEvent = 1'h0;
    chk("wake", sleeping, 15'h0);
    wr(32'hFFFF_FFFF);
    wr(32'hFFBF_FFFF);
    cfgWrite = 1'h0;
    tick(4);
    chk("again", sleeping, 15'h1);
    $display("sleep test done");
    report_and_stop;
  end
endmodule // memory_configuration_register_tb_top
`default_nettype wire
